// >>> hw/fpm_entry.sv
// Notes on behaviour
// - primary pin low at reset release means normal operation; secondary pin ignored.
// - programming only with primary high, secondary low; both high is prohibited.
// - mode is latched from the pins at reset release.
// - after entry, count up to 11 pulses on the primary pin.
// - zero pulses selects asynchronous serial mode on serial port zero.
// - receive bit time is measured from the programmer's first reset command.
// - rates 9600 to 153600 bit/s; top rate barred at 2.5 MHz or less.
// - pins not used for programming keep their post-reset state.
// - programming talks only over serial port zero transmit and receive pins.
`timescale 1ns/1ns
`default_nettype none
module fpm_entry (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // mode pins
  input  wire logic        primary_mode_pin,
  input  wire logic        secondary_mode_pin,
  // peripheral clock is above 2.5 MHz
  input  wire logic        periph_clk_fast,
  // serial port zero pins
  input  wire logic        device_serial_rx_pin,
  output logic             device_serial_tx_pin,
  // transmit data from the flash firmware
  input  wire logic        tx_bit,
  // mode status
  output logic             normal_mode,
  output logic             prog_mode,
  output logic             mode_error,
  output logic [3:0]       comm_mode,
  output logic             link_ready,
  output logic [15:0]      bit_cycles,
  output logic             ports_hold_reset_state,
  // low byte of the measured bit time, drained by firmware
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  input  wire logic        rx_ready
);
  fpm_pkg::fpm_state_e st_reg;
  fpm_pkg::fpm_state_e st_next;
  logic [2:0]  p0_sync_reg;
  logic [2:0]  p1_sync_reg;
  logic [2:0]  rx_sync_reg;
  logic [2:0]  sync_fill_reg;
  logic        p0_lvl_reg;
  logic        p0_lvl_next;
  logic        rx_lvl_reg;
  logic        rx_lvl_next;
  logic [3:0]  pulses_reg;
  logic [3:0]  pulses_next;
  logic [23:0] quiet_reg;
  logic [23:0] quiet_next;
  logic [15:0] meas_reg;
  logic [15:0] meas_next;
  logic [15:0] bitc_reg;
  logic [15:0] bitc_next;
  logic        tx_reg;
  logic        tx_next;
  logic        f_in_valid;
  logic        f_in_ready;
  logic        normal_reg;
  logic        normal_next;
  logic        prog_reg;
  logic        prog_next;
  logic        err_reg;
  logic        err_next;
  logic        link_reg;
  logic        link_next;

  // three-stage synchronisers; stage 0 only feeds stage 1
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p0_sync_reg <= fpm_pkg::SYNC_RST;
      p1_sync_reg <= fpm_pkg::SYNC_RST;
      rx_sync_reg <= fpm_pkg::SYNC_RX_RST;
      sync_fill_reg <= fpm_pkg::SYNC_RST;
    end
    else
    begin
      p0_sync_reg <= {p0_sync_reg[1:0], primary_mode_pin};
      p1_sync_reg <= {p1_sync_reg[1:0], secondary_mode_pin};
      rx_sync_reg <= {rx_sync_reg[1:0], device_serial_rx_pin};
      // marks which stages already hold real pin samples after release
      sync_fill_reg <= {sync_fill_reg[1:0], 1'b1};
    end
  end

  always_comb
  begin
    st_next     = st_reg;
    pulses_next = pulses_reg;
    quiet_next  = quiet_reg;
    meas_next   = meas_reg;
    bitc_next   = bitc_reg;
    tx_next     = 1'b1;
    f_in_valid  = 1'b0;
    p0_lvl_next = (p0_sync_reg[2] == p0_sync_reg[1]) ? p0_sync_reg[2] : p0_lvl_reg;
    rx_lvl_next = (rx_sync_reg[2] == rx_sync_reg[1]) ? rx_sync_reg[2] : rx_lvl_reg;
    case (st_reg)
      fpm_pkg::ST_HOLD:
      begin
        // decide only once the last stage holds a real pin sample, not its reset value
        if (sync_fill_reg[2] &&
            p0_sync_reg[2] == p0_sync_reg[1] && p1_sync_reg[2] == p1_sync_reg[1])
        begin
          if (!p0_sync_reg[2])
            st_next = fpm_pkg::ST_NORMAL;
          else if (!p1_sync_reg[2])
            st_next = fpm_pkg::ST_PULSES;
          else
            st_next = fpm_pkg::ST_BAD;
        end
      end
      fpm_pkg::ST_PULSES:
      begin
        // falling edge of the primary pin starts one pulse and counts it
        if (p0_lvl_reg && !p0_lvl_next && pulses_reg != fpm_pkg::MAX_PULSES)
          pulses_next = pulses_reg + 4'h1;
        if (p0_lvl_next != p0_lvl_reg)
          quiet_next = fpm_pkg::QUIET_CNT_RST;
        else if (quiet_reg != 24'(fpm_pkg::PULSE_QUIET_CYC))
          quiet_next = quiet_reg + 24'h000001;
        else if (pulses_reg == fpm_pkg::MODE_UART0)
          st_next = fpm_pkg::ST_MEASURE;
        else
          st_next = fpm_pkg::ST_BAD;
      end
      fpm_pkg::ST_MEASURE:
      begin
        // reset command starts with a start bit then a low-order one: time the low run
        if (!rx_lvl_next && meas_reg != fpm_pkg::BIT_CNT_MAX)
          meas_next = meas_reg + 16'h0001;
        if (rx_lvl_reg && !rx_lvl_next)
          meas_next = 16'h0001;
        if (!rx_lvl_reg && rx_lvl_next && meas_reg != fpm_pkg::BIT_CNT_RST)
        begin
          if (meas_reg > 16'(fpm_pkg::BIT_CYC_MAX + fpm_pkg::BIT_CYC_MAX / 8))
            meas_next = fpm_pkg::BIT_CNT_RST;
          else if (!periph_clk_fast &&
                   meas_reg < 16'(fpm_pkg::BIT_CYC_MIN * 3 / 2))
            meas_next = fpm_pkg::BIT_CNT_RST;
          else
          begin
            bitc_next  = meas_reg;
            f_in_valid = 1'b1;
            st_next    = fpm_pkg::ST_LINK;
          end
        end
      end
      fpm_pkg::ST_LINK:
      begin
        tx_next = tx_bit;
      end
      default:
      begin
        // normal and prohibited states hold until the next reset
        st_next = st_reg;
      end
    endcase
    // status flags follow the next state so each of the four flags comes from its own flop
    normal_next = (st_next == fpm_pkg::ST_NORMAL);
    prog_next   = (st_next == fpm_pkg::ST_PULSES) || (st_next == fpm_pkg::ST_MEASURE) ||
                  (st_next == fpm_pkg::ST_LINK);
    err_next    = (st_next == fpm_pkg::ST_BAD);
    link_next   = (st_next == fpm_pkg::ST_LINK);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg     <= fpm_pkg::ST_HOLD;
      p0_lvl_reg <= 1'b0;
      rx_lvl_reg <= 1'b1;
      pulses_reg <= fpm_pkg::PULSE_CNT_RST;
      quiet_reg  <= fpm_pkg::QUIET_CNT_RST;
      meas_reg   <= fpm_pkg::BIT_CNT_RST;
      bitc_reg   <= fpm_pkg::BIT_CNT_RST;
      tx_reg     <= 1'b1;
      normal_reg <= 1'b0;
      prog_reg   <= 1'b0;
      err_reg    <= 1'b0;
      link_reg   <= 1'b0;
    end
    else
    begin
      st_reg     <= st_next;
      p0_lvl_reg <= p0_lvl_next;
      rx_lvl_reg <= rx_lvl_next;
      pulses_reg <= pulses_next;
      quiet_reg  <= quiet_next;
      meas_reg   <= meas_next;
      bitc_reg   <= bitc_next;
      tx_reg     <= tx_next;
      normal_reg <= normal_next;
      prog_reg   <= prog_next;
      err_reg    <= err_next;
      link_reg   <= link_next;
    end
  end

  // low byte of the measured bit time is queued so firmware can take it at leisure
  fpm_fifo #(
    .WIDTH (fpm_pkg::FIFO_WIDTH),
    .DEPTH (fpm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (f_in_valid && f_in_ready),
    .in_data   (bitc_next[7:0]),
    .in_ready  (f_in_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  always_comb
  begin
    device_serial_tx_pin   = tx_reg;
    normal_mode            = normal_reg;
    prog_mode              = prog_reg;
    mode_error             = err_reg;
    comm_mode              = pulses_reg;
    link_ready             = link_reg;
    bit_cycles             = bitc_reg;
    ports_hold_reset_state = prog_reg;
  end
endmodule
`default_nettype wire

// >>> pkg/fpm_pkg.sv
`default_nettype none
package fpm_pkg;
  // system clock
  localparam int unsigned CLK_HZ = 50000000;
  // mode-pin pulse counting
  localparam logic [3:0] MAX_PULSES = 4'hb;
  localparam logic [3:0] PULSE_CNT_RST = 4'h0;
  localparam logic [3:0] MODE_UART0 = 4'h0;
  // quiet time on the primary mode pin that closes the pulse phase, in us
  localparam int unsigned PULSE_QUIET_US = 1000;
  localparam int unsigned PULSE_QUIET_CYC = CLK_HZ / 1000000 * PULSE_QUIET_US;
  localparam logic [23:0] QUIET_CNT_RST = 24'h000000;
  // bit-time measurement
  localparam logic [15:0] BIT_CNT_RST = 16'h0000;
  localparam logic [15:0] BIT_CNT_MAX = 16'hffff;
  // slowest supported rate 9600 bit/s, fastest 153600 bit/s
  localparam int unsigned RATE_MIN = 9600;
  localparam int unsigned RATE_MAX = 153600;
  localparam int unsigned BIT_CYC_MAX = CLK_HZ / RATE_MIN;
  localparam int unsigned BIT_CYC_MIN = CLK_HZ / RATE_MAX;
  // highest rate is barred when the peripheral clock is at or below this, in kHz
  localparam int unsigned FAST_RATE_MIN_KHZ = 2500;
  // receive data fifo
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  // sync stages
  localparam logic [2:0] SYNC_RST = 3'h0;
  // the receive line idles high
  localparam logic [2:0] SYNC_RX_RST = 3'h7;
  typedef enum logic [5:0]
  {
    ST_HOLD   = 6'h01,
    ST_NORMAL = 6'h02,
    ST_PULSES = 6'h04,
    ST_MEASURE = 6'h08,
    ST_LINK   = 6'h10,
    ST_BAD    = 6'h20
  } fpm_state_e;
endpackage
`default_nettype wire

// >>> hw/fpm_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
)(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;
  logic             valid_reg;

  always_comb
  begin
    in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    out_valid = valid_reg;
    out_data  = mem[rd_reg];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_next   = push ? ((wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next   = pop ? ((rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
      valid_reg <= 1'b0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
      // registered not-empty flag so the drain valid comes from a flop
      valid_reg <= (cnt_next != '0);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// >>> tb/fpm_entry_sva.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_entry_sva (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // pins
  input wire logic        primary_mode_pin,
  input wire logic        secondary_mode_pin,
  input wire logic        periph_clk_fast,
  input wire logic        device_serial_rx_pin,
  input wire logic        device_serial_tx_pin,
  input wire logic        tx_bit,
  // status
  input wire logic        normal_mode,
  input wire logic        prog_mode,
  input wire logic        mode_error,
  input wire logic [3:0]  comm_mode,
  input wire logic        link_ready,
  input wire logic [15:0] bit_cycles,
  input wire logic        ports_hold_reset_state,
  // drain side
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_data,
  input wire logic        rx_ready
);
  localparam int BMAX = fpm_pkg::BIT_CYC_MAX + fpm_pkg::BIT_CYC_MAX / 8;
  localparam int BMIN = fpm_pkg::BIT_CYC_MIN * 3 / 2;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rel;
    $rose(rst_n);
  endsequence
  sequence s_decided;
    ##[0:5] (normal_mode || prog_mode || mode_error);
  endsequence
  property p_decide;
    s_rel |-> s_decided;
  endproperty
  a_decide: assert property (p_decide) else $error("mode not decided");
  property p_one;
    $onehot0({normal_mode, prog_mode, mode_error});
  endproperty
  a_one: assert property (p_one) else $error("two modes at once");
  property p_norm;
    normal_mode |=> normal_mode && comm_mode == 4'h0 && !link_ready;
  endproperty
  a_norm: assert property (p_norm) else $error("normal mode left");
  property p_prog;
    prog_mode |=> prog_mode || mode_error;
  endproperty
  a_prog: assert property (p_prog) else $error("prog mode lost");
  property p_hold;
    prog_mode |-> ports_hold_reset_state;
  endproperty
  a_hold: assert property (p_hold) else $error("ports not held");
  property p_cnt;
    comm_mode <= fpm_pkg::MAX_PULSES;
  endproperty
  a_cnt: assert property (p_cnt) else $error("pulse count too big");
  property p_uart;
    link_ready |-> prog_mode && comm_mode == fpm_pkg::MODE_UART0;
  endproperty
  a_uart: assert property (p_uart) else $error("link without uart mode");
  property p_txidle;
    !link_ready |=> device_serial_tx_pin;
  endproperty
  a_txidle: assert property (p_txidle) else $error("tx not idle");
  property p_txfol;
    link_ready |=> device_serial_tx_pin == $past(tx_bit);
  endproperty
  a_txfol: assert property (p_txfol) else $error("tx not following");
  property p_rate;
    $rose(link_ready) |-> bit_cycles <= BMAX && (periph_clk_fast || bit_cycles >= BMIN);
  endproperty
  a_rate: assert property (p_rate) else $error("bit time out of range");
  property p_link;
    link_ready |=> link_ready && $stable(bit_cycles);
  endproperty
  a_link: assert property (p_link) else $error("bit time moved");
  property p_byte;
    $rose(rx_valid) |-> rx_data == bit_cycles[7:0];
  endproperty
  a_byte: assert property (p_byte) else $error("bad fifo byte");
endmodule
bind fpm_entry fpm_entry_sva i_fpm_entry_sva (.*);
`default_nettype wire

// >>> tb/fpm_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_prog_model (
  // clock
  input wire logic sys_clk,
  // programmer drives
  output logic     rst_n,
  output logic     primary_mode_pin,
  output logic     secondary_mode_pin,
  output logic     device_serial_rx_pin,
  // programmer receives device tx
  input wire logic device_serial_tx_pin
);
  // the bench supplies the operating clock on sys_clk
  initial
  begin
    rst_n = 1'b0;
    primary_mode_pin = 1'b0;
    secondary_mode_pin = 1'b0;
    device_serial_rx_pin = 1'b1;
  end
  // only this model resets; both pins high only when commanded
  task automatic enter(input logic p, input logic s);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    primary_mode_pin <= p;
    secondary_mode_pin <= s;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      primary_mode_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      primary_mode_pin <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
    @(negedge sys_clk);
  endtask
  task automatic wiggle(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      secondary_mode_pin <= ~secondary_mode_pin;
    end
    @(negedge sys_clk);
  endtask
  task automatic send_low(input int n);
    @(posedge sys_clk);
    device_serial_rx_pin <= 1'b0;
    repeat (n) @(posedge sys_clk);
    device_serial_rx_pin <= 1'b1;
    @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/fpm_entry_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fpm_entry_tb;
  logic        sys_clk, rst_n, primary_mode_pin, secondary_mode_pin, periph_clk_fast;
  logic        device_serial_rx_pin, device_serial_tx_pin, tx_bit, normal_mode, prog_mode;
  logic        mode_error, link_ready, ports_hold_reset_state, rx_valid, rx_ready, t;
  logic [3:0]  comm_mode;
  logic [15:0] bit_cycles;
  logic [7:0]  rx_data;
  logic [31:0] seed = 32'h00017b5a;
  int          fails, comparisons, i, n, exp;
  int          q[$];
  fpm_entry i_fpm_entry (.*);
  fpm_prog_model u_prog (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic results();
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] want);
    comparisons++;
    if (got !== want)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_flags(input logic [2:0] want);
    chk_val({13'h0000, normal_mode, prog_mode, mode_error}, {13'h0000, want});
  endtask
  task automatic tmo(input logic ok);
    if (ok !== 1'b1)
    begin
      fails++;
      results();
    end
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) tx_bit <= ^xs();
  initial
  begin
    periph_clk_fast = 1'b1;
    rx_ready = 1'b0;
    u_prog.enter(1'b0, ^xs());
    chk_flags(3'b100);
    u_prog.enter(1'b1, 1'b1);
    chk_flags(3'b001);
    u_prog.enter(1'b1, 1'b0);
    u_prog.pulse(12);
    repeat (8) @(negedge sys_clk);
    chk_val({12'h000, comm_mode}, 16'h000b);
    u_prog.enter(1'b1, 1'b0);
    chk_flags(3'b010);
    chk_val({15'h0000, ports_hold_reset_state}, 16'h0001);
    u_prog.wiggle(6);
    chk_flags(3'b010);
    repeat (fpm_pkg::PULSE_QUIET_CYC + 16) @(negedge sys_clk);
    @(posedge sys_clk) periph_clk_fast <= 1'b0;
    // too short a start bit for a slow peripheral clock is dropped
    u_prog.send_low(fpm_pkg::BIT_CYC_MIN);
    repeat (200) @(negedge sys_clk);
    chk_val({15'h0000, link_ready}, 16'h0000);
    n = 488 + int'(xs() % 4700);
    q.push_back(n & 255);
    u_prog.send_low(n);
    for (i = 0; i < 100 && link_ready !== 1'b1; i++) @(negedge sys_clk);
    tmo(link_ready);
    chk_val(bit_cycles, n[15:0]);
    chk_val({12'h000, comm_mode}, 16'h0000);
    @(posedge sys_clk) rx_ready <= 1'b1;
    @(negedge sys_clk);
    for (i = 0; i < 100 && rx_valid !== 1'b1; i++) @(negedge sys_clk);
    tmo(rx_valid);
    exp = q.pop_front();
    chk_val({8'h00, rx_data}, exp[15:0]);
    repeat (8)
    begin
      @(negedge sys_clk) t = tx_bit;
      @(negedge sys_clk) chk_val({15'h0000, device_serial_tx_pin}, {15'h0000, t});
    end
    chk_val({15'h0000, rx_valid}, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
